// *** hwseq_defs.svh ***
// constants for the haptic waveform sequencer: register indices, fields,
// reset values and timing counts
// assumes a 250 MHz pclk and registers reached as aligned 32-bit apb words
`ifndef HWSEQ_DEFS_SVH
`define HWSEQ_DEFS_SVH

// register indices; byte address is four times the index
`define HWSEQ_IDX_CTRL 8'h0C
`define HWSEQ_IDX_SLOT_FIRST 8'h0F
`define HWSEQ_IDX_SLOT_SEVEN 8'h15
`define HWSEQ_IDX_SLOT_EIGHT 8'h16
`define HWSEQ_IDX_LOOP_LO 8'h17
`define HWSEQ_IDX_LOOP_HI 8'h18
`define HWSEQ_IDX_STATUS 8'h19

// field positions
`define HWSEQ_CTRL_START_BIT 0
`define HWSEQ_SLOT_DELAY_BIT 7
`define HWSEQ_NUM_SLOTS 8
`define HWSEQ_LAST_SLOT 3'h7

// reset values
`define HWSEQ_RST_CTRL 8'h00
`define HWSEQ_RST_SLOT 8'h00
`define HWSEQ_RST_LOOP 8'h00

// timing: delay unit in ms, clock period in ps, cycles per delay unit
// worked in ns so the product stays inside a 32-bit integer
`define HWSEQ_DELAY_UNIT_MS 10
`define HWSEQ_CLK_PERIOD_PS 4000
`define HWSEQ_DELAY_CYCLES ((`HWSEQ_DELAY_UNIT_MS * 1000000) / (`HWSEQ_CLK_PERIOD_PS / 1000))

`endif

// *** hwseq_engine_model.sv ***
// model of the drive engine: plays each requested waveform for lat+1 clocks
// assumes drive.req is held until drive_done has been seen
`timescale 1ns/1ps
module hwseq_engine_model (
   pclk,
   presetn,
   drive,
   lat,
   drive_done
);
   import hwseq_pkg::*;
   input wire logic pclk;
   input wire logic presetn;
   input wire hwseq_pkg::hwseq_drive_t drive;
   input wire logic [2:0] lat; // play length, 0 answers one clock after the request
   output logic drive_done;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic done_next;
   // count play time; no second pulse while the request is still falling
   always_comb begin
      cnt_next = 3'h0;
      done_next = 1'b0;
      if (drive.req && !drive_done) begin
         if (cnt_reg >= lat) begin
            done_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 3'h1;
         end
      end
   end
   // register the count and the one-clock done pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 3'h0;
         drive_done <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         drive_done <= done_next;
      end
   end
endmodule : hwseq_engine_model

// *** hwseq_pkg.sv ***
// types shared by the haptic waveform sequencer files
// assumes nothing beyond the apb signalling of its users
package hwseq_pkg;
   // apb request from the master
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } hwseq_apb_req_t;

   // apb answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } hwseq_apb_rsp_t;

   // request to the waveform drive engine
   typedef struct packed {
      logic req;
      logic [6:0] index;
   } hwseq_drive_t;

   // one sequence slot: delay flag and seven-bit field
   typedef struct packed {
      logic delay;
      logic [6:0] field;
   } hwseq_slot_t;

   // playback states
   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_FETCH,
      SEQ_PLAY,
      SEQ_WAIT,
      SEQ_NEXT
   } hwseq_state_t;
endpackage : hwseq_pkg

// *** hwseq_props.sv ***
// checker for the sequencer ports: apb answers and the drive handshake
// assumes it is bound into hwseq_top and sees only its ports
`timescale 1ns/1ps
module hwseq_props #(
   parameter int unsigned TICK_CYCLES = 10
) (
   pclk,
   presetn,
   apb_req,
   apb_rsp,
   drive_done,
   drive,
   busy
);
   import hwseq_pkg::*;
   input wire logic pclk;
   input wire logic presetn;
   input wire hwseq_pkg::hwseq_apb_req_t apb_req;
   input wire hwseq_pkg::hwseq_apb_rsp_t apb_rsp;
   input wire logic drive_done;
   input wire hwseq_pkg::hwseq_drive_t drive;
   input wire logic busy;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // register index of the current transfer
   logic [7:0] idx;
   assign idx = apb_req.paddr[9:2];
   ////////////////////////////////////////////////////////////////////////////
   // two quiet cycles after a play: step on, then fetch
   sequence s_gap;
      !drive.req ##1 !drive.req;
   endsequence
   // software write that sets the start bit
   sequence s_go;
      apb_req.psel && apb_req.penable && apb_req.pwrite && idx == 8'h0C && apb_req.pwdata[0];
   endsequence
   a_ready_rises: assert property (!apb_rsp.pready |=> apb_rsp.pready)
      else $error("pready stayed low");
   a_access_ready: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
      else $error("access without pready");
   a_unmapped_err: assert property (apb_req.psel && !apb_req.penable && idx != 8'h0C
      && (idx < 8'h0F || idx > 8'h19) |=> apb_rsp.pslverr)
      else $error("unmapped index without pslverr");
   // start lands at the access edge, the engine leaves idle one edge later
   a_start_busy: assert property (s_go ##0 !busy |=> ##1 busy)
      else $error("start did not raise busy");
   a_idle_quiet: assert property (!busy |-> !drive.req)
      else $error("waveform requested while idle");
   a_index_steady: assert property (drive.req && !drive_done |=> $stable(drive.index))
      else $error("index moved during a play");
   a_done_drops: assert property (drive.req && drive_done |=> !drive.req)
      else $error("request held after done");
   // step and fetch keep the request low for two samples before the next play
   a_play_gap: assert property ($fell(drive.req) |-> s_gap)
      else $error("next play came too soon");
endmodule : hwseq_props
bind hwseq_top hwseq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .drive_done(drive_done), .drive(drive), .busy(busy));

// *** hwseq_tb.sv ***
// testbench: apb master, drive engine model and scoreboards for the sequencer
// assumes TICK_CYCLES of 10, so one delay unit is ten clocks
`timescale 1ns/1ps
module testbench;
   import hwseq_pkg::*;
   localparam int TICK = 10;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic drive_done;
   logic busy;
   logic [2:0] lat = 3'h0;
   logic req_d = 1'b0;
   logic [31:0] rnd = 32'h8BED;
   hwseq_apb_req_t req = '0;
   hwseq_apb_rsp_t rsp;
   hwseq_drive_t drive;
   logic [32:0] rd_q[$]; // expected {pslverr, prdata}
   logic [22:0] play_q[$]; // expected {gap ceiling, gap floor, index}
   int num_errors = 0;
   int comparisons = 0;
   int gap = 0;
   hwseq_top #(.TICK_CYCLES(TICK)) u_hwseq_top (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .drive_done(drive_done), .drive(drive), .busy(busy));
   hwseq_engine_model u_hwseq_engine_model (.pclk(pclk), .presetn(presetn), .drive(drive),
      .lat(lat), .drive_done(drive_done));
   initial forever #2 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
      comparisons++;
      if (exp !== got) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic complete_run();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // one apb transfer; held until pready is seen at an access edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
         input logic [32:0] exp);
      req.paddr <= {2'h0, idx, 2'h0};
      req.pwrite <= wr;
      req.pwdata <= {24'h0, wd};
      req.psel <= 1'b1;
      if (!wr) rd_q.push_back(exp);
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // load slots, note the expected plays, start and wait for the end
   task automatic run_seq(input logic [7:0] s[8], input logic [7:0] hi);
      int g;
      int h;
      g = 0;
      h = 0;
      for (int i = 0; i < 8; i++) apb(1'b1, 8'h0F + 8'(i), s[i], '0);
      apb(1'b1, 8'h17, 8'h00, '0);
      apb(1'b1, 8'h18, hi, '0);
      for (int i = 0; i < 8 && s[i] != 8'h00; i++)
         for (int r = 0; r <= (i > 3 ? int'(hi[2*(i-4) +: 2]) : 0); r++)
            if (s[i][7]) begin
               // each delay pass may add a few cycles of fetch and step
               g += TICK * s[i][6:0];
               h += TICK * s[i][6:0] + 6;
            end else begin
               play_q.push_back({8'(h), 8'(g), s[i][6:0]});
               g = 2;
               h = 8;
            end
      lat <= 3'(rnd);
      apb(1'b1, 8'h0C, 8'h01, '0);
      // busy rises only one edge after the start write lands
      @(posedge pclk);
      for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge pclk);
      chk("busy at end", '0, 33'(busy));
      chk("plays left", '0, 33'(play_q.size()));
      apb(1'b0, 8'h0C, 8'h00, '0);
   endtask : run_seq
   ////////////////////////////////////////////////////////////////////////////
   // watch reads and plays against the oldest notes
   always @(posedge pclk) begin
      logic [22:0] e;
      if (req.psel && req.penable && rsp.pready && !req.pwrite && rd_q.size() > 0)
         chk("read data", rd_q.pop_front(), {rsp.pslverr, rsp.prdata});
      if (drive.req === 1'b1 && !req_d) begin
         e = play_q.size() > 0 ? play_q.pop_front() : 23'h7FFFFF;
         chk("play index", 33'(e[6:0]), 33'(drive.index));
         if (e[14:7] >= 8'd10) chk("idle gap", '0, 33'(gap < e[14:7] || gap > e[22:15]));
         gap = 0;
      end
      if (drive.req !== 1'b1) gap++;
      req_d = drive.req;
   end
   initial begin
      repeat (30000) @(posedge pclk);
      num_errors++;
      complete_run();
   end
   initial begin
      logic [7:0] s[8];
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h15, 8'h00, 33'h0);
      apb(1'b0, 8'h16, 8'h00, 33'h0);
      apb(1'b0, 8'h0D, 8'h00, 33'h1_0000_0000);
      for (int k = 0; k < 4; k++) begin
         rnd = xs(rnd);
         for (int i = 0; i < 8; i++) s[i] = {1'b0, 7'(rnd >> (i * 3)) | 7'h01};
         if (k == 1) s[2] = 8'h00;
         if (k == 2) s[6] = 8'h83;
         if (k == 3) s[7] = 8'h80;
         run_seq(s, rnd[15:8]);
         apb(1'b0, 8'h15, 8'h00, {25'h0, s[6]});
         apb(1'b0, 8'h16, 8'h00, {25'h0, s[7]});
      end
      complete_run();
   end
endmodule : testbench

// *** hwseq_tick.sv ***
// divider giving a one-cycle pulse every delay unit
// assumes restart is pulsed when a new delay begins
`timescale 1ns/1ps
module hwseq_tick #(
   parameter int unsigned TICK_CYCLES = 2500000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   output logic tick
);
   import hwseq_pkg::*;

   logic [31:0] cnt_reg; // cycles into the current unit
   logic [31:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   ////////////////////////////////////////////////////////////////////////
   // count up to the unit length, pulse at the end, restart aligns phase
   always_comb begin
      cnt_next = cnt_reg + 32'h1;
      tick_next = 1'b0;
      if (restart) begin
         cnt_next = 32'h0;
      end else if (cnt_reg >= TICK_CYCLES - 1) begin
         // end of unit
         cnt_next = 32'h0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 32'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule : hwseq_tick

// *** hwseq_top.sv ***
// haptic waveform sequencer: apb registers and slot playback engine
// assumes an apb master on pclk and a drive engine that pulses drive_done
// once per finished waveform while drive.req is held
//
// Notes on behaviour
// - delay flag set: slot idles, no waveform
// - idle time is 10 ms times field
// - delay flag clear: field is library index
// - start bit begins playback at first slot
// - advance to next slot when nonzero
// - end after the eighth slot
// - zero entry stops sequence at once
// - repeat count n plays slot n+1 times
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "hwseq_defs.svh"
module hwseq_top #(
   parameter int unsigned TICK_CYCLES = `HWSEQ_DELAY_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire hwseq_pkg::hwseq_apb_req_t apb_req,
   output hwseq_pkg::hwseq_apb_rsp_t apb_rsp,
   input wire logic drive_done,
   output hwseq_pkg::hwseq_drive_t drive,
   output logic busy
);
   import hwseq_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic start_reg; // start bit, cleared by hardware at the end
   logic start_next;
   hwseq_slot_t slot_reg [`HWSEQ_NUM_SLOTS]; // sequence slots
   hwseq_slot_t slot_next [`HWSEQ_NUM_SLOTS];
   logic [7:0] loop_lo_reg; // repeat counts, slots one to four
   logic [7:0] loop_lo_next;
   logic [7:0] loop_hi_reg; // repeat counts, slots five to eight
   logic [7:0] loop_hi_next;
   logic [1:0] rep_lim [`HWSEQ_NUM_SLOTS]; // per slot repeat count
   hwseq_state_t state_reg;
   hwseq_state_t state_next;
   logic [2:0] slot_ptr_reg; // slot being played
   logic [2:0] slot_ptr_next;
   logic [1:0] rep_reg; // plays done of the current slot minus one
   logic [1:0] rep_next;
   logic [6:0] wait_reg; // delay units left
   logic [6:0] wait_next;
   hwseq_drive_t drive_reg;
   hwseq_drive_t drive_next;
   logic busy_reg;
   logic busy_next;
   hwseq_apb_rsp_t rsp_reg;
   hwseq_apb_rsp_t rsp_next;
   logic tick_restart; // realigns the divider at delay start
   logic tick;
   logic wr_en; // write takes effect this edge
   logic [7:0] wr_byte;
   logic [7:0] acc_idx; // addressed register index
   logic seq_end; // playback finishes this cycle

   ////////////////////////////////////////////////////////////////////////
   // decoding used by read and write paths

   // slot number for a slot index, valid when in the slot range
   function automatic logic [2:0] slot_of(input logic [7:0] idx);
      logic [7:0] d;
      d = idx - `HWSEQ_IDX_SLOT_FIRST;
      slot_of = d[2:0];
   endfunction : slot_of

   // true when the index addresses a slot register
   function automatic logic is_slot(input logic [7:0] idx);
      is_slot = (idx >= `HWSEQ_IDX_SLOT_FIRST) && (idx <= `HWSEQ_IDX_SLOT_EIGHT);
   endfunction : is_slot

   // true when the index is mapped at all
   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = is_slot(idx) || (idx == `HWSEQ_IDX_CTRL) ||
                  (idx == `HWSEQ_IDX_LOOP_LO) || (idx == `HWSEQ_IDX_LOOP_HI) ||
                  (idx == `HWSEQ_IDX_STATUS);
   endfunction : is_mapped

   assign acc_idx = apb_req.paddr[9:2];
   assign wr_byte = apb_req.pwdata[7:0];
   // pready is always high in access, so the access phase is the write edge
   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                  rsp_reg.pready && is_mapped(acc_idx);

   ////////////////////////////////////////////////////////////////////////
   // split the two loop registers into per-slot repeat counts
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_rep
         assign rep_lim[g] = loop_lo_reg[2*g+1:2*g];
         assign rep_lim[g+4] = loop_hi_reg[2*g+1:2*g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // delay unit divider
   hwseq_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .restart(tick_restart),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // register file next values; hardware clear of start loses to a set
   always_comb begin
      slot_next = slot_reg;
      loop_lo_next = loop_lo_reg;
      loop_hi_next = loop_hi_reg;
      start_next = start_reg;
      if (seq_end) begin
         start_next = 1'b0;
      end
      if (wr_en) begin
         if (acc_idx == `HWSEQ_IDX_CTRL) begin
            // software set wins over the end-of-sequence clear
            start_next = wr_byte[`HWSEQ_CTRL_START_BIT];
         end else if (is_slot(acc_idx)) begin
            slot_next[slot_of(acc_idx)] = wr_byte;
         end else if (acc_idx == `HWSEQ_IDX_LOOP_LO) begin
            loop_lo_next = wr_byte;
         end else if (acc_idx == `HWSEQ_IDX_LOOP_HI) begin
            loop_hi_next = wr_byte;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_reg <= 1'b0;
         loop_lo_reg <= `HWSEQ_RST_LOOP;
         loop_hi_reg <= `HWSEQ_RST_LOOP;
         for (int i = 0; i < `HWSEQ_NUM_SLOTS; i++) begin
            slot_reg[i] <= `HWSEQ_RST_SLOT;
         end
      end else begin
         start_reg <= start_next;
         loop_lo_reg <= loop_lo_next;
         loop_hi_reg <= loop_hi_next;
         slot_reg <= slot_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer: read data and error latched in setup, zero wait access
   always_comb begin
      rsp_next = rsp_reg;
      rsp_next.pready = 1'b1;
      if (apb_req.psel && !apb_req.penable) begin
         rsp_next.prdata = 32'h0000_0000;
         rsp_next.pslverr = !is_mapped(acc_idx);
         if (acc_idx == `HWSEQ_IDX_CTRL) begin
            rsp_next.prdata[0] = start_reg;
         end else if (is_slot(acc_idx)) begin
            rsp_next.prdata[7:0] = slot_reg[slot_of(acc_idx)];
         end else if (acc_idx == `HWSEQ_IDX_LOOP_LO) begin
            rsp_next.prdata[7:0] = loop_lo_reg;
         end else if (acc_idx == `HWSEQ_IDX_LOOP_HI) begin
            rsp_next.prdata[7:0] = loop_hi_reg;
         end else if (acc_idx == `HWSEQ_IDX_STATUS) begin
            // engine state: busy, slot, delaying, repeat pass
            rsp_next.prdata[7:0] = {1'b0, rep_reg, state_reg == SEQ_WAIT,
                                    slot_ptr_reg, busy_reg};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // playback engine
   always_comb begin
      state_next = state_reg;
      slot_ptr_next = slot_ptr_reg;
      rep_next = rep_reg;
      wait_next = wait_reg;
      drive_next = drive_reg;
      busy_next = busy_reg;
      tick_restart = 1'b0;
      seq_end = 1'b0;
      case (state_reg)
         SEQ_IDLE: begin
            if (start_reg) begin
               // begin at the first slot
               slot_ptr_next = 3'h0;
               rep_next = 2'h0;
               busy_next = 1'b1;
               state_next = SEQ_FETCH;
            end
         end
         SEQ_FETCH: begin
            if (slot_reg[slot_ptr_reg] == `HWSEQ_RST_SLOT) begin
               // zero entry: nothing later plays
               seq_end = 1'b1;
               busy_next = 1'b0;
               state_next = SEQ_IDLE;
            end else if (slot_reg[slot_ptr_reg].delay) begin
               // timed idle, drive stays quiet
               wait_next = slot_reg[slot_ptr_reg].field;
               tick_restart = 1'b1;
               state_next = SEQ_WAIT;
            end else begin
               // field selects the library waveform
               drive_next.req = 1'b1;
               drive_next.index = slot_reg[slot_ptr_reg].field;
               state_next = SEQ_PLAY;
            end
         end
         SEQ_PLAY: begin
            if (drive_done) begin
               drive_next.req = 1'b0;
               state_next = SEQ_NEXT;
            end
         end
         SEQ_WAIT: begin
            // one unit of 10 ms per tick
            if (wait_reg == 7'h00) begin
               state_next = SEQ_NEXT;
            end else if (tick) begin
               wait_next = wait_reg - 7'h01;
            end
         end
         SEQ_NEXT: begin
            if (rep_reg != rep_lim[slot_ptr_reg]) begin
               // play the same slot again
               rep_next = rep_reg + 2'h1;
               state_next = SEQ_FETCH;
            end else if (slot_ptr_reg == `HWSEQ_LAST_SLOT) begin
               // eighth slot done
               seq_end = 1'b1;
               busy_next = 1'b0;
               state_next = SEQ_IDLE;
            end else begin
               rep_next = 2'h0;
               slot_ptr_next = slot_ptr_reg + 3'h1;
               state_next = SEQ_FETCH;
            end
         end
         default: begin
            state_next = SEQ_IDLE;
         end
      endcase
      // software clearing start aborts playback at once
      if (!start_reg && state_reg != SEQ_IDLE) begin
         drive_next.req = 1'b0;
         busy_next = 1'b0;
         state_next = SEQ_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SEQ_IDLE;
         slot_ptr_reg <= 3'h0;
         rep_reg <= 2'h0;
         wait_reg <= 7'h00;
         drive_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         slot_ptr_reg <= slot_ptr_next;
         rep_reg <= rep_next;
         wait_reg <= wait_next;
         drive_reg <= drive_next;
         busy_reg <= busy_next;
      end
   end

   assign apb_rsp = rsp_reg;
   assign drive = drive_reg;
   assign busy = busy_reg;
endmodule : hwseq_top
